// ===== rtl/hsc_pkg.sv
// Constants and types for the high-speed capture port
`default_nettype none

package hsc_pkg;

    // System clock and port clock rates
    localparam int CLK_HZ = 25_000_000;
    localparam int FAST_HZ = 8_000_000;
    localparam int SLOW_HZ = 4_000_000;
    // Half periods rounded up, never above the rate
    localparam logic [3:0] HALF_FAST = 4'((CLK_HZ + 2 * FAST_HZ - 1) / (2 * FAST_HZ));
    localparam logic [3:0] HALF_SLOW = 4'((CLK_HZ + 2 * SLOW_HZ - 1) / (2 * SLOW_HZ));

    // Framing
    localparam logic [5:0] WORD_BITS = 6'h20;
    localparam logic [5:0] SMALL_PKG_BITS = 6'h08;
    localparam logic [2:0] GAP_CYCLES = 3'h7;
    localparam int FIFO_DEPTH = 8;
    localparam int NUM_WORDS = 16;
    localparam logic [3:0] LAST_WORD = 4'hF;

    // Word spans of each content selection
    localparam logic [4:0] ALL_FIRST = 5'h00;
    localparam logic [4:0] ALL_COUNT = 5'h10;
    localparam logic [4:0] WAVE_FIRST = 5'h00;
    localparam logic [4:0] WAVE_COUNT = 5'h07;
    localparam logic [4:0] POWER_FIRST = 5'h07;
    localparam logic [4:0] POWER_COUNT = 5'h09;

    // Register indices; byte address is four times the index
    localparam int ADDR_W = 18;
    localparam logic [15:0] CFG_IDX = 16'hE706;
    localparam logic [15:0] CTRL_IDX = 16'hE708;
    localparam logic [15:0] STAT_IDX = 16'hE709;

    // Reset values and field positions
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DROP_BIT = 1;
    localparam int STAT_LEVEL_LSB = 4;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        XFER_ALL = 2'b00,
        XFER_WAVES = 2'b01,
        XFER_POWERS = 2'b10,
        XFER_RESERVED = 2'b11
    } hsc_xfer_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SHIFT = 2'b01,
        ST_GAP = 2'b10
    } hsc_state_e;

    typedef enum logic [1:0] {
        SEL_NONE = 2'b00,
        SEL_CFG = 2'b01,
        SEL_CTRL = 2'b10,
        SEL_STAT = 2'b11
    } hsc_sel_e;

    // Port configuration register, bit 0 first from the bottom
    typedef struct packed {
        logic [1:0] reserved;
        logic frame_select_polarity;
        hsc_xfer_e transfer_content_select;
        logic package_gap_enable;
        logic package_size_select;
        logic clock_rate_select;
    } hsc_cfg_s;

    // One set of values from the metering core, in transmit order
    typedef struct packed {
        logic [31:0] phase_a_current_sample;
        logic [31:0] phase_a_voltage_sample;
        logic [31:0] phase_b_current_sample;
        logic [31:0] phase_b_voltage_sample;
        logic [31:0] phase_c_current_sample;
        logic [31:0] phase_c_voltage_sample;
        logic [31:0] neutral_current_sample;
        logic [31:0] phase_a_apparent_power;
        logic [31:0] phase_b_apparent_power;
        logic [31:0] phase_c_apparent_power;
        logic [31:0] phase_a_total_active_power;
        logic [31:0] phase_b_total_active_power;
        logic [31:0] phase_c_total_active_power;
        logic [31:0] phase_a_fundamental_reactive_power;
        logic [31:0] phase_b_fundamental_reactive_power;
        logic [31:0] phase_c_fundamental_reactive_power;
    } hsc_samples_s;

    // Port pins
    typedef struct packed {
        logic clk;
        logic data;
        logic frame;
    } hsc_pins_s;

endpackage

`default_nettype wire

// ===== rtl/hsc_fifo.sv
// Word FIFO between the sample loader and the serialiser
`timescale 1ns/1ns
`default_nettype none

module hsc_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // Fill level
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rd_q;
    logic [CW-1:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready = cnt_q != FULL;
    assign out_valid = cnt_q != '0;
    assign out_data = mem_q[rd_q];
    assign level = cnt_q;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointers wrap naturally; depth is a power of two
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + PW'(1);
            end
            if (pop) begin
                rd_q <= rd_q + PW'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (push && !pop) begin
            cnt_q <= cnt_q + CW'(1);
        end else if (pop && !push) begin
            cnt_q <= cnt_q - CW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

endmodule

`default_nettype wire

// ===== rtl/hsc_port.sv
// High-speed capture port: registers, sample loader and serial framer
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none

// Operation
// - Size bit 0: each value goes as one 32-bit package, MSB first.
// - Size bit 1: each value splits into four 8-bit packages, MSB first.
// - Gap bit 0: packages follow back to back without idle clocks.
// - Gap bit 1: seven idle port clock cycles between successive packages.
// - Selector 00: all sixteen words, samples then apparent, active, reactive powers.
// - Selector 01: seven waveform samples only, neutral current last.
// - Selector 10: nine power values only, apparent then active then reactive.
// - Selector 11 behaves exactly like the sixteen-word selection.
// - Polarity bit 0: frame select pin is active low.
// - Polarity bit 1: frame select pin is active high.
// - Config bits 7:6 reset to zero and steer nothing.
module hsc_port
    import hsc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // AXI4-Lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Values from the metering core
    input wire hsc_samples_s sample_set,
    input wire logic sample_valid,
    output logic sample_ready,
    // Port pins
    output logic stream_clock_pin,
    output logic stream_data_pin,
    output logic frame_select_pin
);

    // Register decode shared by reads and writes
    function automatic hsc_sel_e reg_select(input logic [ADDR_W-1:0] addr);
        hsc_sel_e sel;
        sel = SEL_NONE;
        if (addr[ADDR_W-1:2] == CFG_IDX) begin
            sel = SEL_CFG;
        end else if (addr[ADDR_W-1:2] == CTRL_IDX) begin
            sel = SEL_CTRL;
        end else if (addr[ADDR_W-1:2] == STAT_IDX) begin
            sel = SEL_STAT;
        end
        return sel;
    endfunction

    // First word and word count of a content selection
    function automatic logic [9:0] content_span(input hsc_xfer_e xfer);
        logic [9:0] span;
        case (xfer)
            XFER_WAVES: begin
                span = {WAVE_FIRST, WAVE_COUNT};
            end
            XFER_POWERS: begin
                span = {POWER_FIRST, POWER_COUNT};
            end
            XFER_ALL: begin
                span = {ALL_FIRST, ALL_COUNT};
            end
            default: begin
                span = {ALL_FIRST, ALL_COUNT};
            end
        endcase
        return span;
    endfunction

    // Registers
    hsc_cfg_s cfg_q;
    logic [7:0] ctrl_q;
    logic drop_q;
    logic enable;

    // Bus slave state
    logic aw_held_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic w_held_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic do_write;
    logic do_read;
    hsc_sel_e wr_sel;
    hsc_sel_e rd_sel;
    logic [31:0] rd_word;

    // Loader state
    logic ld_busy_q;
    hsc_samples_s snap_q;
    logic [4:0] ld_idx_q;
    logic [4:0] ld_end_q;
    logic [9:0] span;
    logic [3:0] word_pos;
    logic capture;
    logic drop_set;

    // FIFO
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [31:0] fifo_out_data;
    logic [3:0] fifo_level;

    // Serialiser state
    hsc_state_e st_q;
    hsc_state_e st_d;
    logic [3:0] hp_q;
    logic [3:0] half;
    logic sclk_q;
    logic tick;
    logic rise;
    logic fall;
    logic [31:0] shift_q;
    logic [5:0] left_q;
    logic [5:0] sent_q;
    logic [5:0] pkg_len;
    logic [2:0] gap_q;
    logic lat_rate_q;
    logic lat_size_q;
    logic lat_gap_q;
    logic load;
    logic shift_en;
    logic pkg_clr;
    logic frame_active;
    logic busy;
    hsc_pins_s pins_q;

    assign enable = ctrl_q[CTRL_ENABLE_BIT];

    // Bus handshakes
    assign s_axi_awready = !aw_held_q;
    assign s_axi_wready = !w_held_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign do_write = aw_held_q && w_held_q && !bvalid_q;
    assign do_read = s_axi_arvalid && !rvalid_q;
    assign wr_sel = reg_select(aw_addr_q);
    assign rd_sel = reg_select(s_axi_araddr);

    // Address and data may arrive in either order
    always_ff @(posedge clk) begin
        if (rst) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= '0;
        end else if (s_axi_awvalid && !aw_held_q) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            w_held_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else if (s_axi_wvalid && !w_held_q) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (do_write) begin
            w_held_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Only the low byte lane holds register bits
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_q <= hsc_cfg_s'(CFG_RESET);
            ctrl_q <= CTRL_RESET;
        end else if (do_write && w_strb_q[0]) begin
            if (wr_sel == SEL_CFG) begin
                cfg_q <= hsc_cfg_s'(w_data_q[7:0]);
            end
            if (wr_sel == SEL_CTRL) begin
                ctrl_q <= w_data_q[7:0];
            end
        end
    end

    // New drop wins over a clear
    always_ff @(posedge clk) begin
        if (rst) begin
            drop_q <= 1'b0;
        end else begin
            drop_q <= drop_set || (drop_q && !(do_write && w_strb_q[0]
                && wr_sel == SEL_STAT && w_data_q[STAT_DROP_BIT]));
        end
    end

    always_comb begin
        rd_word = '0;
        case (rd_sel)
            SEL_CFG: begin
                rd_word[7:0] = cfg_q;
            end
            SEL_CTRL: begin
                rd_word[7:0] = ctrl_q;
            end
            SEL_STAT: begin
                rd_word[STAT_BUSY_BIT] = busy;
                rd_word[STAT_DROP_BIT] = drop_q;
                rd_word[STAT_LEVEL_LSB +: 4] = fifo_level;
            end
            default: begin
                rd_word = '0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else if (do_read) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Loader: snapshot one value set, push the selected words in order
    assign sample_ready = enable && !ld_busy_q;
    assign capture = sample_valid && sample_ready;
    assign drop_set = sample_valid && !sample_ready;
    assign span = content_span(cfg_q.transfer_content_select);
    assign word_pos = LAST_WORD - ld_idx_q[3:0];

    always_ff @(posedge clk) begin
        if (rst) begin
            ld_busy_q <= 1'b0;
            ld_idx_q <= '0;
            ld_end_q <= '0;
        end else if (capture) begin
            ld_busy_q <= 1'b1;
            ld_idx_q <= span[9:5];
            ld_end_q <= span[9:5] + span[4:0];
        end else if (ld_busy_q && fifo_in_ready) begin
            ld_idx_q <= ld_idx_q + 5'h01;
            if (ld_idx_q + 5'h01 == ld_end_q) begin
                ld_busy_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            snap_q <= '0;
        end else if (capture) begin
            snap_q <= sample_set;
        end
    end

    hsc_fifo #(
        .WIDTH(32),
        .DEPTH(FIFO_DEPTH)
    ) i_hsc_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(ld_busy_q),
        .in_ready(fifo_in_ready),
        .in_data(snap_q[{word_pos, 5'h00} +: 32]),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data),
        .level(fifo_level)
    );

    assign fifo_out_ready = load;
    assign busy = ld_busy_q || fifo_out_valid || (st_q != ST_IDLE);

    // Port clock divider, runs only outside the idle state
    assign half = lat_rate_q ? HALF_SLOW : HALF_FAST;
    assign tick = (st_q != ST_IDLE) && (hp_q == half - 4'h1);
    assign rise = tick && !sclk_q;
    assign fall = tick && sclk_q;

    always_ff @(posedge clk) begin
        if (rst || st_q == ST_IDLE || load) begin
            hp_q <= '0;
            sclk_q <= 1'b0;
        end else if (tick) begin
            hp_q <= '0;
            sclk_q <= !sclk_q;
        end else begin
            hp_q <= hp_q + 4'h1;
        end
    end

    assign pkg_len = lat_size_q ? SMALL_PKG_BITS : WORD_BITS;

    // Framing state machine; bits change on falling port clock edges
    always_comb begin
        st_d = st_q;
        load = 1'b0;
        shift_en = 1'b0;
        pkg_clr = 1'b0;
        case (st_q)
            ST_IDLE: begin
                if (enable && fifo_out_valid) begin
                    load = 1'b1;
                    st_d = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (fall && (left_q == '0 || sent_q == pkg_len)) begin
                    pkg_clr = 1'b1;
                    if (lat_gap_q) begin
                        st_d = ST_GAP;
                    end else if (left_q != '0) begin
                        shift_en = 1'b1;
                    end else if (enable && fifo_out_valid) begin
                        load = 1'b1;
                    end else begin
                        st_d = ST_IDLE;
                    end
                end else if (fall) begin
                    shift_en = 1'b1;
                end
            end
            ST_GAP: begin
                if (fall && gap_q == GAP_CYCLES) begin
                    st_d = ST_SHIFT;
                    if (left_q != '0) begin
                        shift_en = 1'b1;
                    end else if (enable && fifo_out_valid) begin
                        load = 1'b1;
                    end else begin
                        st_d = ST_IDLE;
                    end
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= ST_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // Rate, size and gap settings are taken per word so a word never mixes them
    always_ff @(posedge clk) begin
        if (rst) begin
            lat_rate_q <= 1'b0;
            lat_size_q <= 1'b0;
            lat_gap_q <= 1'b0;
        end else if (load) begin
            lat_rate_q <= cfg_q.clock_rate_select;
            lat_size_q <= cfg_q.package_size_select;
            lat_gap_q <= cfg_q.package_gap_enable;
        end
    end

    // Shift register, MSB first
    always_ff @(posedge clk) begin
        if (rst) begin
            shift_q <= '0;
        end else if (load) begin
            shift_q <= fifo_out_data;
        end else if (shift_en) begin
            shift_q <= {shift_q[30:0], 1'b0};
        end
    end

    // Bits left in the word and bits sent in the package
    always_ff @(posedge clk) begin
        if (rst) begin
            left_q <= '0;
            sent_q <= '0;
        end else begin
            if (load) begin
                left_q <= WORD_BITS;
            end else if (rise && st_q == ST_SHIFT) begin
                left_q <= left_q - 6'h01;
            end
            if (load || pkg_clr) begin
                sent_q <= '0;
            end else if (rise && st_q == ST_SHIFT) begin
                sent_q <= sent_q + 6'h01;
            end
        end
    end

    // Idle port clock periods counted during a gap
    always_ff @(posedge clk) begin
        if (rst || st_q != ST_GAP) begin
            gap_q <= '0;
        end else if (rise) begin
            gap_q <= gap_q + 3'h1;
        end
    end

    // Pins registered; clock held low outside packages
    assign frame_active = st_q == ST_SHIFT;

    always_ff @(posedge clk) begin
        if (rst) begin
            pins_q <= '{clk: 1'b0, data: 1'b0, frame: 1'b1};
        end else begin
            pins_q.clk <= sclk_q && frame_active;
            pins_q.data <= shift_q[31] && frame_active;
            if (cfg_q.frame_select_polarity) begin
                pins_q.frame <= frame_active;
            end else begin
                pins_q.frame <= !frame_active;
            end
        end
    end

    assign stream_clock_pin = pins_q.clk;
    assign stream_data_pin = pins_q.data;
    assign frame_select_pin = pins_q.frame;

endmodule

`default_nettype wire

// ===== verif/hsc_port_monitor.sv
// Port-level checker for the capture port
`timescale 1ns/1ns
`default_nettype none
module hsc_port_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Sample side and pins
    input wire logic sample_ready,
    input wire logic stream_clock_pin,
    input wire logic stream_data_pin
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rise;
        $rose(stream_clock_pin);
    endsequence
    AST_WR_ANSWER: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_R_STANDS: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
    AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("arready during answer");
    AST_CLK_LOW: assert property (s_rise |-> $past(!stream_clock_pin, 2))
        else $error("port clock low phase short");
    AST_CLK_HIGH: assert property ($fell(stream_clock_pin) |-> $past(stream_clock_pin, 2))
        else $error("port clock high phase short");
    AST_CLK_MAX: assert property (s_rise |-> ##[2:4] !stream_clock_pin)
        else $error("port clock high phase long");
    AST_DATA_HOLD: assert property (stream_clock_pin && $past(stream_clock_pin) |->
        $stable(stream_data_pin)) else $error("data moved while clock high");
    AST_RST_IDLE: assert property (disable iff (1'b0) rst |=> !stream_clock_pin &&
        !stream_data_pin && !s_axi_bvalid && !s_axi_rvalid && !sample_ready)
        else $error("not idle after reset");
endmodule
bind hsc_port hsc_port_monitor i_hsc_port_monitor (.*);
`default_nettype wire

// ===== verif/hsc_host_model.sv
// Host receiver model
`timescale 1ns/1ns
`default_nettype none
module hsc_host_model (
    // System clock and control
    input wire logic clk,
    input wire logic clr,
    input wire logic pol,
    // Port pins
    input wire logic sclk,
    input wire logic sdata,
    input wire logic frame
);
    logic [31:0] words [0:31];
    logic [31:0] sh;
    logic [4:0] nb;
    logic [4:0] n_words;
    logic ps;
    logic pa;
    int n_frames, n_stray, hi_cnt, hi_len, gap_cnt, gap_min;
    wire logic act = (frame === pol);
    always @(posedge clk) begin
        ps <= sclk;
        pa <= act;
        if (sclk) begin
            hi_cnt <= hi_cnt + 1;
        end else begin
            if (ps) hi_len <= hi_cnt;
            hi_cnt <= 0;
        end
        if (clr) begin
            n_words <= 0;
            nb <= 0;
            n_frames <= 0;
            n_stray <= 0;
            hi_len <= 0;
            gap_cnt <= 999;
            gap_min <= 999;
        end else begin
            gap_cnt <= act ? 0 : (gap_cnt < 999 ? gap_cnt + 1 : gap_cnt);
            if (act && !pa) begin
                n_frames <= n_frames + 1;
                if (n_frames > 0 && gap_cnt < gap_min) gap_min <= gap_cnt;
            end
            if (sclk && !ps && !act) n_stray <= n_stray + 1;
            if (sclk && !ps && act) begin
                sh <= {sh[30:0], sdata};
                nb <= nb + 5'h01;
                if (nb == 5'h1F) begin
                    words[n_words] <= {sh[30:0], sdata};
                    n_words <= n_words + 5'h01;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking testbench for the capture port
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import hsc_pkg::*;
    localparam logic [17:0] A_CFG = {CFG_IDX, 2'b00};
    localparam logic [17:0] A_CTRL = {CTRL_IDX, 2'b00};
    localparam logic [17:0] A_STAT = {STAT_IDX, 2'b00};
    logic clk = 0;
    logic rst = 1;
    logic [ADDR_W-1:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0;
    logic [3:0] s_axi_wstrb = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, sample_valid = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    hsc_samples_s sample_set = '0;
    logic sample_ready, stream_clock_pin, stream_data_pin, frame_select_pin;
    logic pol = 0, clr = 0;
    int n_mismatch = 0, checks = 0, cyc = 0;
    hsc_port i_hsc_port (.*);
    hsc_host_model i_hsc_host_model (.clk, .clr, .pol, .sclk(stream_clock_pin),
        .sdata(stream_data_pin), .frame(frame_select_pin));
    initial begin
        forever #20 clk = ~clk;
    end
    function automatic logic [31:0] w(input int k);
        return {k[3:0], 28'h5A3C96F} ^ 32'(k * 3);
    endfunction
    task finish_test;
        if (n_mismatch == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task axi_wr(input logic [17:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
        do @(posedge clk); while (!s_axi_bvalid);
        chk(32'(s_axi_bresp), 32'(er));
        s_axi_bready <= 1'b0;
    endtask
    task axi_rd(input logic [17:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (!s_axi_rvalid);
        chk(s_axi_rdata, exp);
        chk(32'(s_axi_rresp), 32'(er));
        s_axi_rready <= 1'b0;
    endtask
    // Register map and drop flag
    task t_regs;
        axi_rd(A_CFG, 32'h0, RESP_OKAY);
        axi_wr(A_CFG, 32'hC0, RESP_OKAY);
        axi_rd(A_CFG, 32'hC0, RESP_OKAY);
        axi_rd(18'h00100, 32'h0, RESP_SLVERR);
        axi_wr(18'h00100, 32'h1, RESP_SLVERR);
        @(posedge clk);
        sample_valid <= 1'b1;
        @(posedge clk);
        sample_valid <= 1'b0;
        axi_rd(A_STAT, 32'h2, RESP_OKAY);
        axi_wr(A_STAT, 32'h2, RESP_OKAY);
        axi_rd(A_STAT, 32'h0, RESP_OKAY);
    endtask
    // One set through the port
    task t_stream(input logic [7:0] cfg, input int first, input int cnt, input int np,
        input int half);
        axi_wr(A_CFG, {24'h0, cfg}, RESP_OKAY);
        axi_wr(A_CTRL, 32'h1, RESP_OKAY);
        @(posedge clk);
        pol <= cfg[5];
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        chk(32'(sample_ready), 32'h1);
        sample_valid <= 1'b1;
        @(posedge clk);
        sample_valid <= 1'b0;
        while (i_hsc_host_model.n_words < 5'(cnt)) @(posedge clk);
        while (frame_select_pin !== !cfg[5]) @(posedge clk);
        for (int k = 0; k < cnt; k++) begin
            chk(i_hsc_host_model.words[k], w(first + k));
        end
        chk(32'(i_hsc_host_model.n_words), 32'(cnt));
        chk(32'(i_hsc_host_model.n_frames), 32'(np));
        chk(32'(i_hsc_host_model.hi_len), 32'(half));
        chk(32'(i_hsc_host_model.n_stray), 32'h0);
        if (cfg[2]) chk(32'(i_hsc_host_model.gap_min >= 14 * half), 32'h1);
        axi_wr(A_CTRL, 32'h0, RESP_OKAY);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_mismatch++;
            finish_test;
        end
    end
    initial begin
        for (int k = 0; k < 16; k++) sample_set[511 - 32 * k -: 32] = w(k);
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_stream(8'h00, 0, 16, 1, 2);
        t_stream(8'h0B, 0, 7, 1, 4);
        t_stream(8'h34, 7, 9, 9, 2);
        t_stream(8'hDE, 0, 16, 64, 2);
        finish_test;
    end
endmodule
`default_nettype wire
